// ### shared/fse_pkg.sv
/*
  constants shared by the frequency sweep engine files.
  assumes a byte wide register port and a 250 MHz system clock.
*/
package fse_pkg;
  // word widths
  localparam int unsigned FSE_FW = 48;   // tuning and step words
  localparam int unsigned FSE_RW = 20;   // step interval count
  // byte offsets, multi-byte words are most significant byte first
  localparam logic [5:0] FSE_LOW_ADDR  = 6'h04;  // low / first word
  localparam logic [5:0] FSE_HIGH_ADDR = 6'h0a;  // high frequency word
  localparam logic [5:0] FSE_STEP_ADDR = 6'h10;  // delta step word
  localparam logic [5:0] FSE_RATE_ADDR = 6'h1a;  // step interval count
  localparam logic [5:0] FSE_CTRL_ADDR = 6'h1f;  // sweep control
  // sweep control field positions
  localparam int unsigned FSE_CLR_FREQ_BIT = 7;
  localparam int unsigned FSE_CLR_BOTH_BIT = 6;
  localparam int unsigned FSE_TRI_BIT      = 5;
  localparam int unsigned FSE_MODE_LSB     = 1;
  // mode field encodings
  localparam logic [2:0] FSE_MODE_RAMP  = 3'h2;
  localparam logic [2:0] FSE_MODE_CHIRP = 3'h3;
  // reset values
  localparam logic [7:0]  FSE_CTRL_RST = 8'h00;
  localparam logic [19:0] FSE_RATE_RST = 20'h00001;
  localparam logic [47:0] FSE_WORD_RST = 48'h000000000000;
  // clock rate, for anyone converting step intervals to time
  localparam int unsigned FSE_CLK_PERIOD_NS = 4;
endpackage

// ### shared/fse_rate_if.sv
/*
  link between the sweep core and its step interval down-counter.
  assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface fse_rate_if #(parameter int unsigned W = 20);
  logic         run;      // counter may decrement
  logic         restart;  // load count now, tick not masked
  logic [W-1:0] count;    // programmed interval value
  logic         tick;     // one cycle step pulse
  modport ctl (output run, output restart, output count, input tick);
  modport cnt (input run, input restart, input count, output tick);
endinterface

// ### core/fse_rate_counter.sv
/*
  step interval down-counter: one tick every count+1 clocks.
  assumes count is at least one and restart is a one cycle pulse.
*/
`timescale 1ns/1ns
module fse_rate_counter
  import fse_pkg::*;
#(
  parameter int unsigned W = FSE_RW
)
(
  input  logic    ref_clk,
  input  logic    sys_rst,
  fse_rate_if.cnt rif
);
  typedef struct packed
  {
    logic [W-1:0] cnt;  // remaining count
  } fse_cnt_s;

  fse_cnt_s st_ff;   // registered state
  fse_cnt_s nxt_st;  // next state

  // pulse while the count sits at zero and run is high
  assign rif.tick = rif.run && (st_ff.cnt == '0);

  // reload happens at zero or on restart, so without a restart a new count waits for the old one
  always_comb
  begin
    nxt_st = st_ff;
    if (rif.restart)
    begin
      nxt_st.cnt = rif.count;
    end
    else if (rif.run)
    begin
      if (st_ff.cnt == '0)
      begin
        nxt_st.cnt = rif.count;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ### core/fse_core.sv
/*
  frequency sweep engine: ramped keying and chirp sweeps feeding a
  48-bit phase accumulator, with a byte register port.
  assumes the host drives reg_* on ref_clk; keying pin and update
  strobe are asynchronous pins and are synchronised here.
*/
`timescale 1ns/1ns
module fse_core
  import fse_pkg::*;
(
  input  logic        ref_clk,
  input  logic        sys_rst,
  input  logic [5:0]  reg_addr,
  input  logic [7:0]  reg_wdata,
  input  logic        reg_wr,
  output logic [7:0]  reg_rdata,
  input  logic        keying_select_pin,
  input  logic        update_strobe,
  output logic [47:0] tuning_word,
  output logic [47:0] phase_word,
  output logic        ramp_done
);
  typedef struct packed
  {
    logic        key_m;    // keying pin, first sync stage
    logic        key_s;    // keying pin, synchronised
    logic        key_q;    // previous synchronised level
    logic        upd_m;    // update strobe, first sync stage
    logic        upd_s;    // update strobe, synchronised
    logic        upd_q;    // previous synchronised level
    logic [47:0] sh_lo;    // buffered low / first tuning word
    logic [47:0] sh_hi;    // buffered high frequency word
    logic [47:0] sh_step;  // buffered delta step word
    logic [19:0] sh_rate;  // buffered step interval count
    logic [7:0]  sh_ctrl;  // buffered sweep control
    logic [47:0] lo;       // active low / first word
    logic [47:0] hi;       // active high word
    logic [47:0] step;     // active delta step word
    logic [19:0] rate;     // active interval count
    logic [7:0]  ctrl;     // active sweep control
    logic        clr_p;    // one cycle accumulator clear pulse
    logic        tri_q;    // triangle enable, previous cycle
    logic        dir;      // triangle direction, 1 = upward
    logic [47:0] acc;      // frequency accumulator
    logic [47:0] phase;    // phase accumulator
    logic [47:0] tune;     // word presented to the phase accumulator
    logic [7:0]  rdata;    // read data
  } fse_st_s;

  fse_st_s st_ff;   // registered state
  fse_st_s nxt_st;  // next state

  fse_rate_if #(.W(FSE_RW)) rif ();

  // replace one byte of a 48-bit word, byte 0 is the top byte
  function automatic logic [47:0] wr_byte(input logic [47:0] w,
                                          input logic [5:0]  off,
                                          input logic [7:0]  d);
    logic [47:0] r;
    r = w;
    r[(5 - off) * 8 +: 8] = d;
    return r;
  endfunction

  // pick one byte of a 48-bit word, byte 0 is the top byte
  function automatic logic [7:0] rd_byte(input logic [47:0] w,
                                         input logic [5:0]  off);
    return w[(5 - off) * 8 +: 8];
  endfunction

  // decoded controls, from the active copy and the synchronised pins
  logic [2:0]  mode;      // active mode field
  logic        is_ramp;   // ramped keying selected
  logic        is_chirp;  // chirp selected
  logic        clr_both;  // hold both accumulators cleared
  logic        tri_on;    // triangle sweep enabled
  logic        tri_rise;  // triangle just switched on
  logic        upd_rise;  // update strobe rising edge
  logic        key_chg;   // keying pin changed level
  logic        dest_hi;   // ramp heading toward the high word
  logic [47:0] span;      // high word minus low word
  logic [47:0] end_val;   // accumulator value at the destination
  logic        at_end;    // accumulator sits at the destination

  assign mode     = st_ff.ctrl[FSE_MODE_LSB +: 3];
  assign is_ramp  = (mode == FSE_MODE_RAMP);
  assign is_chirp = (mode == FSE_MODE_CHIRP);
  assign clr_both = st_ff.ctrl[FSE_CLR_BOTH_BIT];
  assign tri_on   = is_ramp && st_ff.ctrl[FSE_TRI_BIT];
  assign tri_rise = tri_on && !st_ff.tri_q;
  assign upd_rise = st_ff.upd_s && !st_ff.upd_q;
  assign key_chg  = st_ff.key_s ^ st_ff.key_q;
  // triangle ignores the pin and follows its own direction
  assign dest_hi  = tri_on ? st_ff.dir : st_ff.key_s;
  assign span     = st_ff.hi - st_ff.lo;
  assign end_val  = dest_hi ? span : FSE_WORD_RST;
  assign at_end   = (st_ff.acc == end_val);

  // counter runs until the destination in ramped mode, and is gated
  // by the hold pin in chirp mode; clear-both stops it outright
  assign rif.count   = st_ff.rate;
  assign rif.run     = !clr_both &&
                       ((is_ramp && !at_end) ||
                        (is_chirp && !st_ff.key_s));
  assign rif.restart = clr_both || st_ff.clr_p || tri_rise ||
                       (is_ramp && !tri_on && key_chg);

  fse_rate_counter #(.W(FSE_RW)) u_rate
  (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .rif     (rif)
  );

  // outputs straight from flip-flops, except ramp_done, decoded from them
  assign reg_rdata   = st_ff.rdata;
  assign tuning_word = st_ff.tune;
  assign phase_word  = st_ff.phase;
  assign ramp_done   = is_ramp && !tri_on && at_end;

  // next state: pins, register port, update, sweep and phase
  always_comb
  begin
    nxt_st = st_ff;
    // two stage synchronisers, edge detect on the second stage only
    nxt_st.key_m = keying_select_pin;
    nxt_st.key_s = st_ff.key_m;
    nxt_st.key_q = st_ff.key_s;
    nxt_st.upd_m = update_strobe;
    nxt_st.upd_s = st_ff.upd_m;
    nxt_st.upd_q = st_ff.upd_s;

    // writes land in the buffered copy at any time
    if (reg_wr)
    begin
      if (reg_addr >= FSE_LOW_ADDR && reg_addr < FSE_HIGH_ADDR)
      begin
        nxt_st.sh_lo = wr_byte(st_ff.sh_lo, reg_addr - FSE_LOW_ADDR,
                               reg_wdata);
      end
      else if (reg_addr >= FSE_HIGH_ADDR && reg_addr < FSE_STEP_ADDR)
      begin
        nxt_st.sh_hi = wr_byte(st_ff.sh_hi, reg_addr - FSE_HIGH_ADDR,
                               reg_wdata);
      end
      else if (reg_addr >= FSE_STEP_ADDR &&
               reg_addr < FSE_STEP_ADDR + 6'h06)
      begin
        nxt_st.sh_step = wr_byte(st_ff.sh_step,
                                 reg_addr - FSE_STEP_ADDR,
                                 reg_wdata);
      end
      else if (reg_addr >= FSE_RATE_ADDR &&
               reg_addr < FSE_RATE_ADDR + 6'h03)
      begin
        // 0x1a holds the top four bits, 0x1c the lowest byte
        unique case (reg_addr - FSE_RATE_ADDR)
          6'h00:   nxt_st.sh_rate[19:16] = reg_wdata[3:0];
          6'h01:   nxt_st.sh_rate[15:8]  = reg_wdata;
          default: nxt_st.sh_rate[7:0]   = reg_wdata;
        endcase
      end
      else if (reg_addr == FSE_CTRL_ADDR)
      begin
        nxt_st.sh_ctrl = reg_wdata;
      end
    end

    // read back the buffered copy, unmapped bytes read zero
    nxt_st.rdata = 8'h00;
    if (reg_addr >= FSE_LOW_ADDR && reg_addr < FSE_HIGH_ADDR)
    begin
      nxt_st.rdata = rd_byte(st_ff.sh_lo, reg_addr - FSE_LOW_ADDR);
    end
    else if (reg_addr >= FSE_HIGH_ADDR && reg_addr < FSE_STEP_ADDR)
    begin
      nxt_st.rdata = rd_byte(st_ff.sh_hi, reg_addr - FSE_HIGH_ADDR);
    end
    else if (reg_addr >= FSE_STEP_ADDR &&
             reg_addr < FSE_STEP_ADDR + 6'h06)
    begin
      nxt_st.rdata = rd_byte(st_ff.sh_step, reg_addr - FSE_STEP_ADDR);
    end
    else if (reg_addr == FSE_RATE_ADDR)
    begin
      nxt_st.rdata = {4'h0, st_ff.sh_rate[19:16]};
    end
    else if (reg_addr == FSE_RATE_ADDR + 6'h01)
    begin
      nxt_st.rdata = st_ff.sh_rate[15:8];
    end
    else if (reg_addr == FSE_RATE_ADDR + 6'h02)
    begin
      nxt_st.rdata = st_ff.sh_rate[7:0];
    end
    else if (reg_addr == FSE_CTRL_ADDR)
    begin
      nxt_st.rdata = st_ff.sh_ctrl;
    end

    // the buffered set engages only on an update strobe edge; the
    // clear pulse is one clock long and re-fires on every edge with the buffered clear bit set
    nxt_st.clr_p = 1'b0;
    if (upd_rise)
    begin
      nxt_st.lo    = st_ff.sh_lo;
      nxt_st.hi    = st_ff.sh_hi;
      nxt_st.step  = st_ff.sh_step;
      nxt_st.rate  = st_ff.sh_rate;
      nxt_st.ctrl  = st_ff.sh_ctrl;
      nxt_st.clr_p = st_ff.sh_ctrl[FSE_CLR_FREQ_BIT];
    end
    nxt_st.tri_q = tri_on;

    // frequency accumulator, clear-both wins over everything
    if (clr_both)
    begin
      nxt_st.acc = FSE_WORD_RST;
    end
    else if (st_ff.clr_p)
    begin
      // back to the start point; the step word is left alone
      if (is_chirp)
      begin
        nxt_st.acc = FSE_WORD_RST;
      end
      else
      begin
        nxt_st.acc = dest_hi ? FSE_WORD_RST : span;
      end
    end
    else if (tri_rise)
    begin
      // start at the word the pin selects, head for the other one
      nxt_st.acc = st_ff.key_s ? span : FSE_WORD_RST;
      nxt_st.dir = !st_ff.key_s;
    end
    else if (rif.tick)
    begin
      if (is_chirp)
      begin
        // signed step, modulo wrap keeps it inside the 48-bit word, dc up to the clock rate
        nxt_st.acc = st_ff.acc + st_ff.step;
      end
      else if (dest_hi)
      begin
        // upward; a step past the end lands exactly on it
        if (span - st_ff.acc <= st_ff.step)
        begin
          nxt_st.acc = span;
        end
        else
        begin
          nxt_st.acc = st_ff.acc + st_ff.step;
        end
      end
      else
      begin
        // downward toward the low word
        if (st_ff.acc <= st_ff.step)
        begin
          nxt_st.acc = FSE_WORD_RST;
        end
        else
        begin
          nxt_st.acc = st_ff.acc - st_ff.step;
        end
      end
    end
    else if (tri_on && at_end)
    begin
      // triangle turns round instead of stopping
      nxt_st.dir = !st_ff.dir;
    end

    // word fed to the phase accumulator, one clock behind acc
    if (clr_both)
    begin
      nxt_st.tune = FSE_WORD_RST;
    end
    else if (is_ramp || is_chirp)
    begin
      nxt_st.tune = st_ff.lo + st_ff.acc;
    end
    else
    begin
      nxt_st.tune = st_ff.lo;
    end

    // phase accumulator, zero hertz while clear-both is high
    if (clr_both)
    begin
      nxt_st.phase = FSE_WORD_RST;
    end
    else
    begin
      nxt_st.phase = st_ff.phase + st_ff.tune;
    end
  end

  // state register, every field to a constant on reset
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff         <= '0;
      st_ff.sh_rate <= FSE_RATE_RST;
      st_ff.rate    <= FSE_RATE_RST;
      st_ff.sh_ctrl <= FSE_CTRL_RST;
      st_ff.ctrl    <= FSE_CTRL_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ### bench/fse_core_sva.sv
/* port checker for the sweep engine.
   assumes it is bound onto fse_core, one clock domain. */
`timescale 1ns/1ns
module fse_core_sva
  import fse_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [5:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_rdata,
  input wire logic        keying_select_pin,
  input wire logic        update_strobe,
  input wire logic [47:0] tuning_word,
  input wire logic [47:0] phase_word,
  input wire logic        ramp_done
);
  logic [3:0] quiet_ff;  // clocks since strobe or pin change
  logic       pin_ff;    // pin level one clock ago
  default clocking dck @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // sweep checks wait out engagement and pin edges
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      quiet_ff <= 4'h0;
      pin_ff   <= 1'b0;
    end
    else
    begin
      pin_ff <= keying_select_pin;
      if (update_strobe || keying_select_pin != pin_ff)
        quiet_ff <= 4'h0;  // window restarts
      else if (quiet_ff != 4'hf)
        quiet_ff <= quiet_ff + 4'h1;  // saturates
    end
  sequence word_wr;
    reg_wr && reg_addr >= FSE_LOW_ADDR && reg_addr <= 6'h15;
  endsequence
  sequence ctrl_wr;
    reg_wr && reg_addr == FSE_CTRL_ADDR;
  endsequence
  sequence addr_kept;
    !reg_wr && reg_addr == $past(reg_addr);
  endsequence
  word_readback_a: assert property (
    word_wr ##1 addr_kept |=> reg_rdata == $past(reg_wdata, 2))
    else $error("word byte read back wrong");
  ctrl_readback_a: assert property (
    ctrl_wr ##1 addr_kept |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control byte read back wrong");
  rate_nibble_a: assert property (
    reg_addr == FSE_RATE_ADDR |=> reg_rdata[7:4] == 4'h0)
    else $error("rate top nibble not zero");
  unmapped_zero_a: assert property (
    (reg_addr inside {[6'h16:6'h19], 6'h1d, 6'h1e} || reg_addr > 6'h1f
     || reg_addr < FSE_LOW_ADDR) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  phase_acc_a: assert property (
    phase_word != 48'h0 && $past(phase_word) != 48'h0 |->
    phase_word == $past(phase_word) + $past(tuning_word))
    else $error("phase did not add tuning word");
  done_hold_a: assert property (
    ramp_done && $past(ramp_done) && quiet_ff >= 4'h8 |=>
    $stable(tuning_word))
    else $error("tuning moved at destination");
  one_step_a: assert property (
    $changed(tuning_word) && quiet_ff >= 4'h8 |=> $stable(tuning_word))
    else $error("tuning moved two clocks running");
  done_arrive_a: assert property (
    $rose(ramp_done) && quiet_ff >= 4'h8 |=> $changed(tuning_word))
    else $error("done rose without a final step");
endmodule
bind fse_core fse_core_sva fse_core_sva_inst (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .ramp_done(ramp_done),
  .keying_select_pin(keying_select_pin), .update_strobe(update_strobe),
  .tuning_word(tuning_word), .phase_word(phase_word));

// ### bench/fse_host.sv
/* host model: byte register writes, keying pin and update strobe.
   assumes callers enter its tasks just after a ref_clk edge. */
`timescale 1ns/1ns
module fse_host
  import fse_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic [5:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            keying_select_pin,
  output logic            update_strobe
);
  // idle levels from time zero
  initial
  begin
    reg_addr          = 6'h00;
    reg_wdata         = 8'h00;
    reg_wr            = 1'b0;
    keying_select_pin = 1'b0;
    update_strobe     = 1'b0;
  end
  // n edges, then 1 ns more so nothing races the edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // top byte at the lowest address, strobe held across the bytes
  task automatic put(input logic [5:0] a, input logic [47:0] v,
                     input int nb);
    reg_wr = 1'b1;
    for (int i = 0; i < nb; i++)
    begin
      reg_addr  = a + 6'(i);
      reg_wdata = v[8*(nb-1-i) +: 8];
      step(1);
    end
    reg_wr    = 1'b0;
    reg_wdata = ~reg_wdata;  // released data stops showing the byte
    step(1);  // idle clock, so reg_wr is seen low before a following put re-raises it
  endtask
  task automatic wr_word(input logic [5:0] a, input logic [47:0] v);
    put(a, v, 6);
  endtask
  task automatic wr_rate(input logic [19:0] v);
    put(FSE_RATE_ADDR, {28'h0, v}, 3);
  endtask
  task automatic wr_ctrl(input logic [7:0] v);
    put(FSE_CTRL_ADDR, {40'h0, v}, 1);
  endtask
  // read data lands one clock after the address
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_addr = a;
    step(1);
    d = reg_rdata;
  endtask
  // only once writes are done; two clocks high covers the sync flops
  task automatic update();
    update_strobe = 1'b1;
    step(2);
    update_strobe = 1'b0;
  endtask
  task automatic pin(input logic v);
    keying_select_pin = v;
    step(1);
  endtask
endmodule

// ### bench/tb_top.sv
/* bench for the sweep engine: scenario tasks over the host model.
   assumes core, host model and checker are compiled before it. */
`timescale 1ns/1ns
module tb_top
  import fse_pkg::*;
;
  localparam logic [47:0] LOW  = 48'h0000_2000_0000;  // ramp low word
  localparam logic [47:0] HIGH = LOW + 48'h350;       // off step grid
  localparam logic [47:0] TOP  = LOW + 48'h400;       // triangle top
  localparam logic [47:0] CF2  = 48'h0000_1000_0000;  // later first word
  logic        ref_clk;
  logic        sys_rst;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic [7:0]  reg_rdata;
  logic        keying_select_pin;
  logic        update_strobe;
  logic [47:0] tuning_word;
  logic [47:0] phase_word;
  logic        ramp_done;
  int          err_count = 0;
  int          n_checks = 0;
  fse_core fse_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .keying_select_pin(keying_select_pin),
    .update_strobe(update_strobe), .tuning_word(tuning_word),
    .phase_word(phase_word), .ramp_done(ramp_done));
  fse_host fse_host_inst (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .keying_select_pin(keying_select_pin), .update_strobe(update_strobe));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic results();
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for a tuning value; running out ends the run
  task automatic wait_word(input logic [47:0] v);
    int t;
    t = 0;
    while (tuning_word !== v && t < 5000)
    begin
      fse_host_inst.step(1);
      t++;
    end
    check(tuning_word, v);
    if (tuning_word !== v)
      results();
  endtask
  // follows n tuning steps: each dl in size, gap clocks after the last
  task automatic watch(input int n, input logic [47:0] dl, input int gap);
    logic [47:0] prev;
    int          t;
    int          last;
    prev = tuning_word;
    t    = 0;
    last = -1;
    while (n > 0)
    begin
      fse_host_inst.step(1);
      t++;
      if (t > 5000)
      begin
        check(tuning_word, prev + dl);
        results();
      end
      if (tuning_word !== prev)
      begin
        check(tuning_word - prev, dl);
        if (last >= 0)
          check(48'(t - last), 48'(gap));
        last = t;
        prev = tuning_word;
        n--;
      end
    end
  endtask
  task automatic reg_scn();
    logic [7:0]  d;
    logic [47:0] v;
    v = 48'h0123_4567_89ab;
    fse_host_inst.wr_word(FSE_STEP_ADDR, v);
    for (int i = 0; i < 6; i++)
    begin
      fse_host_inst.rd(FSE_STEP_ADDR + 6'(i), d);
      check({40'h0, d}, {40'h0, v[8*(5-i) +: 8]});
    end
    fse_host_inst.wr_rate(20'hf_fffe);
    fse_host_inst.rd(FSE_RATE_ADDR, d);
    check({40'h0, d}, 48'h0f);
    fse_host_inst.rd(6'h1c, d);
    check({40'h0, d}, 48'hfe);
    fse_host_inst.rd(6'h16, d);
    check({40'h0, d}, 48'h00);
  endtask
  task automatic ramp_scn();
    fse_host_inst.wr_word(FSE_LOW_ADDR, LOW);
    fse_host_inst.wr_word(FSE_HIGH_ADDR, HIGH);
    fse_host_inst.wr_word(FSE_STEP_ADDR, 48'h100);
    fse_host_inst.wr_rate(20'h3);
    fse_host_inst.wr_ctrl(8'h04);  // ramped keying
    fse_host_inst.update();
    wait_word(LOW);
    fse_host_inst.pin(1'b1);
    watch(3, 48'h100, 4);
    wait_word(HIGH);
    check({47'h0, ramp_done}, 48'h1);
    fse_host_inst.step(20);
    check(tuning_word, HIGH);
    fse_host_inst.pin(1'b0);
    watch(1, -48'h100, 4);
    fse_host_inst.pin(1'b1);
    watch(1, 48'h100, 4);
  endtask
  task automatic tri_scn();
    fse_host_inst.wr_rate(20'h8);
    fse_host_inst.wr_word(FSE_HIGH_ADDR, TOP);
    fse_host_inst.wr_ctrl(8'h24);  // triangle in ramped keying
    fse_host_inst.update();
    wait_word(TOP);
    watch(1, -48'h100, 9);
    fse_host_inst.pin(1'b0);
    wait_word(LOW);
    watch(1, 48'h100, 9);
  endtask
  task automatic chirp_scn();
    logic [47:0] held;
    fse_host_inst.wr_word(FSE_LOW_ADDR, TOP - 48'h80);
    fse_host_inst.wr_word(FSE_STEP_ADDR, 48'h40);
    fse_host_inst.wr_rate(20'h4);
    fse_host_inst.wr_ctrl(8'h86);  // chirp, accumulator cleared on the update
    fse_host_inst.update();
    wait_word(TOP - 48'h80);
    watch(4, 48'h40, 5);
    fse_host_inst.wr_word(FSE_STEP_ADDR, -48'h10);
    fse_host_inst.update();
    wait_word(TOP - 48'h80);
    watch(2, -48'h10, 5);
    fse_host_inst.pin(1'b1);
    fse_host_inst.step(5);
    held = tuning_word;
    fse_host_inst.wr_rate(20'h9);
    fse_host_inst.wr_ctrl(8'h06);  // chirp, no clear
    fse_host_inst.update();
    fse_host_inst.step(6);
    check(tuning_word, held);
    fse_host_inst.pin(1'b0);
    watch(3, -48'h10, 10);
  endtask
  task automatic clear_scn();
    fse_host_inst.wr_ctrl(8'h46);  // clear both, chirp
    fse_host_inst.update();
    fse_host_inst.step(6);
    check(phase_word, 48'h0);
    fse_host_inst.wr_word(FSE_LOW_ADDR, CF2);
    fse_host_inst.step(20);
    check(phase_word, 48'h0);
    fse_host_inst.wr_ctrl(8'h86);
    fse_host_inst.update();
    wait_word(CF2);
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    sys_rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    reg_scn();
    ramp_scn();
    tri_scn();
    chirp_scn();
    clear_scn();
    results();
  end
endmodule
